// ---- hw/tcs_gl_filter.sv ----
// Purpose: ground difference comparator filter
// Assumes: comparator output synchronous to pclk
// Notes:   one-cycle detect pulse once the level outlasts the filter time
`timescale 1ns/100ps
module tcs_gl_filter (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // comparator and result
  input  wire logic gnd_cmp,
  output logic      gl_detect
);
  localparam logic [10:0] FCYC = 11'(tcs_pkg::GL_FILTER_CYC);
  logic [10:0] cnt;

  // count consecutive high cycles, saturate past the filter time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 11'h000;
    end else if (!gnd_cmp) begin
      cnt <= 11'h000;
    end else if (cnt <= FCYC) begin
      cnt <= cnt + 11'h001;
    end
  end

  // fire once, on the first cycle beyond the filter time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gl_detect <= 1'b0;
    end else begin
      gl_detect <= gnd_cmp && (cnt == FCYC);
    end
  end

  AST_GL_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    !gnd_cmp |=> cnt == 11'h000 && !gl_detect)
    else $error("filter count not restarted on low comparator");
  AST_GL_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(gl_detect) |-> $past(gnd_cmp) && $past(cnt) == FCYC)
    else $error("ground loss declared before filter time");
  COV_GL_GLITCH: cover property (@(posedge pclk) disable iff (!presetn)
    gnd_cmp ##1 !gnd_cmp);
endmodule // tcs_gl_filter

// ---- hw/tcs_pkg.sv ----
// Purpose: shared constants for the thermal cluster and ground loss supervisor
// Assumes: pclk at 100 MHz, APB register access with 32-bit data
// Notes:   timing counts derive from times in their own units
package tcs_pkg;
  // ------------------------------------------------------------
  // clock and structure
  // ------------------------------------------------------------
  localparam int CLK_NS      = 10;
  localparam int NCL         = 6;
  localparam int NWAKE       = 4;
  localparam int GLOBAL_CL   = 5;  // cluster 6, index 5
  localparam int OUT16_CL    = 2;  // cluster 3 feeds output one and six
  // ------------------------------------------------------------
  // register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_STAT   = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_TCODE0 = 8'h10;
  localparam int CFG_POLICY_BIT = 0;
  localparam int CFG_WAKE_LSB   = 8;
  localparam int STAT_SECOND_SHUTDOWN_THRESHOLD_BIT  = 6;
  localparam int STAT_GL_BIT    = 7;
  localparam int STAT_T2SB_BIT  = 8;
  localparam int STAT_W         = 9;
  localparam logic [31:0] RST_CFG  = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  // ------------------------------------------------------------
  // timing and temperature code
  // ------------------------------------------------------------
  localparam int GL_FILTER_NS  = 7000;
  localparam int GL_FILTER_CYC = GL_FILTER_NS / CLK_NS;
  localparam int RESTART_NS    = 1_000_000_000;
  localparam int RESTART_CYC   = RESTART_NS / CLK_NS;
  localparam int WINDOW_S      = 60;
  localparam int MAX_FAILS     = 7;
  localparam int TEMP_OFS      = 350;
  localparam int SCALE_NUM     = 2099; // 1/0.488 scaled by 1024
  localparam int SCALE_SHIFT   = 10;
  typedef enum logic [1:0] {
    ST_ON   = 2'b00,
    ST_COOL = 2'b01,
    ST_SBY  = 2'b10
  } tcs_reg_e;
endpackage

// ---- hw/tcs_supervisor.sv ----
// Purpose: thermal cluster shutdown policy, ground loss standby, APB registers
// Assumes: sensor inputs synchronous to pclk, APB slave with zero wait states
// Notes:   shutdown state is the sticky thermal flags; clearing them re-enables loads
`timescale 1ns/100ps
// What this block does
// - six thermal clusters, five local and one global, each with own inputs.
// - per cluster code equals (350 minus temperature) divided by 0.488.
// - policy 0: any first threshold turns off all drivers, pump, auxiliary regulator.
// - primary regulator stays on at first threshold, off at second threshold.
// - standard policy first threshold disables both bus transmitters; receivers stay.
// - policy 1: only the hot cluster's loads switch off.
// - global cluster 6 always causes full standard shutdown.
// - cluster 3 hot in policy 1 turns off output one and six only.
// - comparator high beyond 7 us declares ground loss, forced standby.
// - any enabled wake source leaves forced standby.
// - ground loss flag in status register, readable by host.
// - auxiliary regulator stays off until host clears thermal flag.
// - primary restart after 1 s; 7 failures per minute force standby.
module tcs_supervisor #(
  parameter int SEC_CYC = tcs_pkg::RESTART_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // sensors, comparator, wake sources
  input  wire logic [5:0]  first_shutdown_threshold_hot,
  input  wire logic        second_shutdown_threshold_hot,
  input  wire logic [59:0] temp_c_flat,
  input  wire logic        gnd_cmp,
  input  wire logic [3:0]  wake_src,
  // load controls
  output logic [4:0]       cluster_off,
  output logic             output_one_off,
  output logic             output_six_off,
  output logic             charge_pump_en,
  output logic             aux_reg_en,
  output logic             primary_reg_en,
  output logic             swbus_tx_en,
  output logic             diffbus_tx_en,
  output logic             bus_rx_only,
  output logic             forced_standby,
  output logic             irq
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam logic [31:0] SEC_M1   = 32'(SEC_CYC - 1);
  localparam logic [5:0]  WIN_M1   = 6'(tcs_pkg::WINDOW_S - 1);
  localparam logic [2:0]  FAIL_M1  = 3'(tcs_pkg::MAX_FAILS - 1);
  logic [31:0]             cfg;
  logic [31:0]             mask;
  logic [tcs_pkg::STAT_W-1:0] stat;
  logic [tcs_pkg::STAT_W-1:0] next_stat;
  logic [9:0]              tcode [tcs_pkg::NCL];
  tcs_pkg::tcs_reg_e       state;
  logic [31:0]             cool_cnt;
  logic [31:0]             sec_cnt;
  logic [5:0]              win_sec;
  logic [2:0]              fails;
  logic                    gl_detect;
  logic                    wr_en;
  logic                    rd_setup;
  logic                    addr_ok;
  logic                    policy;
  logic                    global_sd;
  logic                    wake_hit;
  logic                    t2_fail;
  logic                    t2_last;
  logic [5:0]              first_shutdown_threshold;
  logic [31:0]             rd_mux;

  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  // zero wait states keep the master simple; read data is latched at setup
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok  = (paddr == tcs_pkg::OFF_CFG) || (paddr == tcs_pkg::OFF_STAT) ||
                    (paddr == tcs_pkg::OFF_MASK) ||
                    (paddr >= tcs_pkg::OFF_TCODE0 && paddr <= tcs_pkg::OFF_TCODE0 + 8'h14 &&
                     paddr[1:0] == 2'b00);
  assign pslverr  = psel && penable && !addr_ok;

  // read multiplexer, unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == tcs_pkg::OFF_CFG) begin
      rd_mux = cfg;
    end else if (paddr == tcs_pkg::OFF_STAT) begin
      rd_mux = 32'(stat);
    end else if (paddr == tcs_pkg::OFF_MASK) begin
      rd_mux = mask;
    end else if (addr_ok) begin
      rd_mux = 32'(tcode[3'(paddr[4:2] - 3'h4)]);
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // configuration and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg  <= tcs_pkg::RST_CFG;
      mask <= tcs_pkg::RST_MASK;
    end else if (wr_en) begin
      if (paddr == tcs_pkg::OFF_CFG) begin
        cfg <= pwdata & 32'h0000_0F01;
      end
      if (paddr == tcs_pkg::OFF_MASK) begin
        mask <= pwdata & 32'h0000_01FF;
      end
    end
  end

  assign policy = cfg[tcs_pkg::CFG_POLICY_BIT];
  assign wake_hit = |(wake_src & cfg[tcs_pkg::CFG_WAKE_LSB +: tcs_pkg::NWAKE]);

  // ------------------------------------------------------------
  // temperature codes, one per cluster
  // ------------------------------------------------------------
  // fixed-point reciprocal avoids a divider; 25 C gives 666
  for (genvar i = 0; i < tcs_pkg::NCL; i++) begin : g_code
    logic signed [10:0] diff;
    logic        [23:0] prod;
    assign diff = 11'(tcs_pkg::TEMP_OFS) - 11'(signed'(temp_c_flat[i*10 +: 10]));
    assign prod = diff[10] ? 24'h00_0000 : 24'(diff) * 24'(tcs_pkg::SCALE_NUM);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tcode[i] <= 10'h000;
      end else begin
        tcode[i] <= 10'(prod >> tcs_pkg::SCALE_SHIFT);
      end
    end
  end

  // ------------------------------------------------------------
  // sticky status and interrupt
  // ------------------------------------------------------------
  // hardware set wins over a same-cycle write-one-to-clear
  always_comb begin
    next_stat = stat;
    if (wr_en && paddr == tcs_pkg::OFF_STAT) begin
      next_stat = stat & ~pwdata[tcs_pkg::STAT_W-1:0];
    end
    next_stat[5:0] = next_stat[5:0] | first_shutdown_threshold_hot;
    next_stat[tcs_pkg::STAT_SECOND_SHUTDOWN_THRESHOLD_BIT] = next_stat[tcs_pkg::STAT_SECOND_SHUTDOWN_THRESHOLD_BIT] | (second_shutdown_threshold_hot && state == tcs_pkg::ST_ON);
    next_stat[tcs_pkg::STAT_GL_BIT] = next_stat[tcs_pkg::STAT_GL_BIT] | gl_detect;
    next_stat[tcs_pkg::STAT_T2SB_BIT] = next_stat[tcs_pkg::STAT_T2SB_BIT] | t2_fail;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= '0;
    end else begin
      stat <= next_stat;
    end
  end

  assign irq  = |(stat & mask[tcs_pkg::STAT_W-1:0]);
  assign first_shutdown_threshold = stat[5:0];

  // ------------------------------------------------------------
  // first threshold shutdown policy
  // ------------------------------------------------------------
  // loads stay off while the flag is set, so clearing it is the restart
  assign global_sd = (!policy && |first_shutdown_threshold) || first_shutdown_threshold[tcs_pkg::GLOBAL_CL] || forced_standby;
  // only the cluster policy spares loads outside the hot cluster
  for (genvar c = 0; c < 5; c++) begin : g_cl
    assign cluster_off[c] = global_sd || (policy && first_shutdown_threshold[c]);
  end
  assign output_one_off = cluster_off[tcs_pkg::OUT16_CL];
  assign output_six_off = cluster_off[tcs_pkg::OUT16_CL];
  assign charge_pump_en = !global_sd;
  assign aux_reg_en     = !global_sd;
  assign swbus_tx_en    = !global_sd;
  assign diffbus_tx_en  = !global_sd;
  assign bus_rx_only    = global_sd;
  assign primary_reg_en = (state == tcs_pkg::ST_ON);
  assign forced_standby = (state == tcs_pkg::ST_SBY);

  // ------------------------------------------------------------
  // ground loss filter
  // ------------------------------------------------------------
  tcs_gl_filter u_gl_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .gnd_cmp   (gnd_cmp),
    .gl_detect (gl_detect)
  );

  // ------------------------------------------------------------
  // primary regulator restart and forced standby
  // ------------------------------------------------------------
  // the seventh event inside the window gives up and parks in standby
  assign t2_last = (fails == FAIL_M1);
  assign t2_fail = (state == tcs_pkg::ST_ON) && second_shutdown_threshold_hot && t2_last && !gl_detect;

  // regulator state: ground loss wins over everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tcs_pkg::ST_ON;
    end else if (gl_detect) begin
      state <= tcs_pkg::ST_SBY;
    end else begin
      unique case (state)
        tcs_pkg::ST_ON: begin
          if (t2_fail) begin
            state <= tcs_pkg::ST_SBY;
          end else if (second_shutdown_threshold_hot) begin
            state <= tcs_pkg::ST_COOL;
          end
        end
        tcs_pkg::ST_COOL: begin
          if (cool_cnt == SEC_M1) begin
            state <= tcs_pkg::ST_ON;
          end
        end
        tcs_pkg::ST_SBY: begin
          if (wake_hit) begin
            state <= tcs_pkg::ST_ON;
          end
        end
        default: begin
          state <= tcs_pkg::ST_ON;
        end
      endcase
    end
  end

  // off-time counter for the restart delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cool_cnt <= 32'h0000_0000;
    end else if (state != tcs_pkg::ST_COOL) begin
      cool_cnt <= 32'h0000_0000;
    end else begin
      cool_cnt <= cool_cnt + 32'h0000_0001;
    end
  end

  // failure count, cleared when the one-minute window expires or while in forced standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fails   <= 3'h0;
      sec_cnt <= 32'h0000_0000;
      win_sec <= 6'h00;
    end else if (state == tcs_pkg::ST_SBY) begin
      fails   <= 3'h0;
      sec_cnt <= 32'h0000_0000;
      win_sec <= 6'h00;
    end else if (state == tcs_pkg::ST_ON && second_shutdown_threshold_hot && !gl_detect) begin
      fails <= fails + 3'h1;
    end else if (fails != 3'h0) begin
      if (sec_cnt == SEC_M1) begin
        sec_cnt <= 32'h0000_0000;
        if (win_sec == WIN_M1) begin
          win_sec <= 6'h00;
          fails   <= 3'h0;
        end else begin
          win_sec <= win_sec + 6'h01;
        end
      end else begin
        sec_cnt <= sec_cnt + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions and covers
  // ------------------------------------------------------------
  AST_STD_ALL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !policy && first_shutdown_threshold_hot != 6'h00 && !wr_en |=> !charge_pump_en && !aux_reg_en && cluster_off == 5'h1F)
    else $error("standard policy did not shut all loads");
  AST_BUS_RX_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    !policy && first_shutdown_threshold != 6'h00 |-> !swbus_tx_en && !diffbus_tx_en && bus_rx_only)
    else $error("bus transmitters not both off with receive only");
  AST_CLUSTER_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    policy && !wr_en && first_shutdown_threshold_hot == 6'h04 && first_shutdown_threshold == 6'h00 && state == tcs_pkg::ST_ON && !second_shutdown_threshold_hot && !gl_detect
    |=> output_one_off && output_six_off && !cluster_off[0] && charge_pump_en && primary_reg_en)
    else $error("cluster policy shut the wrong loads");
  AST_GLOBAL_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    first_shutdown_threshold_hot[5] |=> cluster_off == 5'h1F && !aux_reg_en && !swbus_tx_en)
    else $error("global cluster did not force full shutdown");
  AST_PRIMARY_SECOND_SHUTDOWN_THRESHOLD: assert property (@(posedge pclk) disable iff (!presetn)
    state == tcs_pkg::ST_ON && second_shutdown_threshold_hot |=> !primary_reg_en)
    else $error("primary regulator not off at second threshold");
  AST_PRIMARY_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
    primary_reg_en && !second_shutdown_threshold_hot && !gl_detect |=> primary_reg_en)
    else $error("primary regulator dropped without second threshold");
  AST_GL_STANDBY: assert property (@(posedge pclk) disable iff (!presetn)
    gl_detect |=> forced_standby && stat[tcs_pkg::STAT_GL_BIT] && !primary_reg_en)
    else $error("ground loss did not force standby and flag");
  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    forced_standby && wake_hit && !gl_detect |=> !forced_standby ##0 primary_reg_en)
    else $error("enabled wake did not leave standby");
  AST_AUX_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    first_shutdown_threshold != 6'h00 && (!policy || first_shutdown_threshold[tcs_pkg::GLOBAL_CL]) && !wr_en |=> !aux_reg_en)
    else $error("auxiliary regulator back on with flag set");
  AST_T2_STANDBY: assert property (@(posedge pclk) disable iff (!presetn)
    t2_fail |=> forced_standby && stat[tcs_pkg::STAT_T2SB_BIT])
    else $error("seventh failure did not force standby");
  AST_TCODE: assert property (@(posedge pclk) disable iff (!presetn)
    temp_c_flat[9:0] == 10'h019 |=> tcode[0] == 10'h29A)
    else $error("temperature code wrong at 25 C");
  // flag capture, shared loads, restart and readback
  AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    first_shutdown_threshold_hot != 6'h00 |=> (first_shutdown_threshold & $past(first_shutdown_threshold_hot)) == $past(first_shutdown_threshold_hot))
    else $error("first threshold flag not captured");
  AST_AUX_CLUSTER: assert property (@(posedge pclk) disable iff (!presetn)
    policy && !wr_en && !first_shutdown_threshold_hot[tcs_pkg::GLOBAL_CL] && !first_shutdown_threshold[tcs_pkg::GLOBAL_CL] && state == tcs_pkg::ST_ON &&
    !second_shutdown_threshold_hot && !gl_detect |=> aux_reg_en && charge_pump_en && swbus_tx_en)
    else $error("cluster policy switched off shared loads");
  AST_T2_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    state == tcs_pkg::ST_ON && second_shutdown_threshold_hot && !t2_last && !gl_detect |=> state == tcs_pkg::ST_COOL)
    else $error("early second threshold event did not start a restart");
  AST_RESTART_TIME: assert property (@(posedge pclk) disable iff (!presetn)
    state == tcs_pkg::ST_COOL && cool_cnt == SEC_M1 && !gl_detect |=> primary_reg_en)
    else $error("primary regulator not restarted after off time");
  AST_GL_FLAG_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && paddr == tcs_pkg::OFF_STAT |=> prdata[tcs_pkg::STAT_GL_BIT] == $past(stat[tcs_pkg::STAT_GL_BIT]))
    else $error("ground loss flag not readable");
  // covers for the main scenarios
  COV_STD: cover property (@(posedge pclk) disable iff (!presetn) !policy && first_shutdown_threshold_hot[1]);
  COV_CL3: cover property (@(posedge pclk) disable iff (!presetn) policy && first_shutdown_threshold_hot[2]);
  COV_RESTART: cover property (@(posedge pclk) disable iff (!presetn)
    state == tcs_pkg::ST_COOL ##1 state == tcs_pkg::ST_ON);
  COV_T2_SBY: cover property (@(posedge pclk) disable iff (!presetn) t2_fail);
endmodule // tcs_supervisor

// ---- sim/tcs_host_model.sv ----
// Purpose: host controller model that drives the supervisor's APB port
// Assumes: single pclk domain; the slave may stretch the access phase
// Notes:   signals change by nonblocking assignment right after a rising edge
`timescale 1ns/100ps
module tcs_host_model (
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  // one transfer; ok stays low if the slave never answers, so a hang is seen
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50 && ok == 1'b0; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        ok  = 1'b1;
        rd  = prdata;
        err = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd; // stale data must not look valid
  endtask
endmodule // tcs_host_model

// ---- sim/tcs_supervisor_tb_top.sv ----
// Purpose: self-checking bench for the thermal and ground loss supervisor
// Assumes: restart time shortened through SEC_CYC
// Notes:   sensor inputs driven by nonblocking assignment on the rising edge
`timescale 1ns/100ps
module tcs_supervisor_tb_top;
  localparam int SEC = 20;
  typedef struct { int temp; logic [9:0] code; } tcs_row_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  first_shutdown_threshold_hot = 6'h00;
  logic        second_shutdown_threshold_hot = 1'b0;
  logic [59:0] temp_c_flat = 60'h0;
  logic        gnd_cmp = 1'b0;
  logic [3:0]  wake_src = 4'h0;
  logic [4:0]  cluster_off;
  logic        oo_off, os_off, cp_en, aux_en, pri_en, sw_tx, df_tx, rx_only, fsb, irq, err, full;
  logic [4:0]  eoff;
  int          bad_count = 0;
  int          total_checks = 0;
  int          n;
  // temperature in, code out: (350 - T) * 2099 / 1024, truncated
  tcs_row_s    rows [6] = '{'{25, 10'h29A}, '{100, 10'h200}, '{-40, 10'h31F},
                           '{150, 10'h199}, '{350, 10'h000}, '{0, 10'h2CD}};
  // free running 100 MHz clock
  always #5 pclk = ~pclk;
  tcs_supervisor #(.SEC_CYC(SEC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_shutdown_threshold_hot(first_shutdown_threshold_hot), .second_shutdown_threshold_hot(second_shutdown_threshold_hot), .temp_c_flat(temp_c_flat), .gnd_cmp(gnd_cmp),
    .wake_src(wake_src), .cluster_off(cluster_off), .output_one_off(oo_off),
    .output_six_off(os_off), .charge_pump_en(cp_en), .aux_reg_en(aux_en),
    .primary_reg_en(pri_en), .swbus_tx_en(sw_tx), .diffbus_tx_en(df_tx),
    .bus_rx_only(rx_only), .forced_standby(fsb), .irq(irq));
  tcs_host_model host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ------------------------------------------------------------
  // report and compare helpers
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t outputs %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer; a silent slave ends the run
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(wr, a, d, rd, err, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk_out({3'h0, pri_en, aux_en, cp_en, fsb, irq}, 8'h1C);
    bus(1'b0, tcs_pkg::OFF_CFG, 32'h0);
    chk_reg(rd, tcs_pkg::RST_CFG);
    chk_out({7'h0, err}, 8'h00);
    bus(1'b0, tcs_pkg::OFF_MASK, 32'h0);
    chk_reg(rd, tcs_pkg::RST_MASK);
    for (int i = 0; i < 6; i++) temp_c_flat[i*10 +: 10] <= 10'(rows[i].temp);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, tcs_pkg::OFF_TCODE0 + 8'(4 * i), 32'h0);
      chk_reg(rd, {22'h0, rows[i].code});
    end
    bus(1'b0, 8'hFC, 32'h0);
    chk_out({7'h0, err}, 8'h01);
    bus(1'b1, tcs_pkg::OFF_MASK, 32'h0000_01FF);
    bus(1'b0, tcs_pkg::OFF_MASK, 32'h0);
    chk_reg(rd, 32'h0000_01FF);
    // every cluster in both policies, cleared by the host afterwards
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, tcs_pkg::OFF_CFG, 32'h100 | 32'(p));
      for (int c = 0; c < 6; c++) begin
        full = (p == 0) || (c == tcs_pkg::GLOBAL_CL);
        eoff = full ? 5'h1F : 5'(1 << c);
        @(posedge pclk);
        first_shutdown_threshold_hot <= 6'(1 << c);
        tick(1);
        chk_out({3'h0, cluster_off}, {3'h0, eoff});
        chk_out({oo_off, os_off, cp_en, aux_en, sw_tx, df_tx, rx_only, pri_en},
                {eoff[2], eoff[2], {4{!full}}, full, 1'b1});
        chk_out({7'h0, irq}, 8'h01);
        @(posedge pclk);
        first_shutdown_threshold_hot <= 6'h00;
        tick(3);
        chk_out({7'h0, aux_en}, {7'h0, !full});
        bus(1'b0, tcs_pkg::OFF_STAT, 32'h0);
        chk_reg(rd, 32'(1 << c));
        bus(1'b1, tcs_pkg::OFF_STAT, 32'(1 << c));
        tick(1);
        chk_out({2'h0, cluster_off, aux_en}, 8'h01);
      end
    end
    // second threshold: six restarts, the seventh failure forces standby
    for (int k = 0; k < 7; k++) begin
      @(posedge pclk);
      second_shutdown_threshold_hot <= 1'b1;
      @(posedge pclk);
      second_shutdown_threshold_hot <= 1'b0;
      tick(1);
      chk_out({6'h0, pri_en, fsb}, {7'h0, k == 6});
      if (k < 6) begin
        tick(SEC - 3);
        chk_out({7'h0, pri_en}, 8'h00);
        for (n = 0; n < 10 && pri_en !== 1'b1; n++) tick(1);
        chk_out({7'h0, pri_en}, 8'h01);
      end
    end
    bus(1'b0, tcs_pkg::OFF_STAT, 32'h0);
    chk_reg(rd, 32'h0000_0140);
    @(posedge pclk);
    wake_src <= 4'h2;
    tick(4);
    chk_out({7'h0, fsb}, 8'h01);
    @(posedge pclk);
    wake_src <= 4'h1;
    tick(3);
    chk_out({6'h0, fsb, pri_en}, 8'h01);
    @(posedge pclk);
    wake_src <= 4'h0;
    bus(1'b1, tcs_pkg::OFF_STAT, 32'h0000_0140);
    // ground loss: an early drop restarts the filter, then a long level trips it
    @(posedge pclk);
    gnd_cmp <= 1'b1;
    tick(600);
    chk_out({7'h0, fsb}, 8'h00);
    @(posedge pclk);
    gnd_cmp <= 1'b0;
    @(posedge pclk);
    gnd_cmp <= 1'b1;
    for (n = 0; n < 800 && fsb !== 1'b1; n++) tick(1);
    chk_out({6'h0, pri_en, 1'(n >= 701 && n <= 704)}, 8'h01);
    @(posedge pclk);
    gnd_cmp <= 1'b0;
    bus(1'b0, tcs_pkg::OFF_STAT, 32'h0);
    chk_reg(rd, 32'h0000_0080);
    bus(1'b1, tcs_pkg::OFF_STAT, 32'h0000_0080);
    @(posedge pclk);
    wake_src <= 4'h1;
    tick(3);
    chk_out({7'h0, fsb}, 8'h00);
    @(posedge pclk);
    wake_src <= 4'h0;
    // masked event keeps irq low; reset in mid-run clears the flag
    bus(1'b1, tcs_pkg::OFF_MASK, 32'h0);
    @(posedge pclk);
    first_shutdown_threshold_hot <= 6'h01;
    tick(2);
    chk_out({2'h0, irq, cluster_off}, 8'h01);
    @(posedge pclk);
    presetn <= 1'b0;
    first_shutdown_threshold_hot <= 6'h00;
    tick(2);
    chk_out({2'h0, cluster_off, pri_en}, 8'h01);
    @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, tcs_pkg::OFF_STAT, 32'h0);
    chk_reg(rd, 32'h0);
    print_verdict();
  end
endmodule // tcs_supervisor_tb_top
